// ==== rtl/bvc_capture.sv ====
// embedded-sync video capture port with a classic wishbone register slave
// assumes pclk_i and video_data_in_i are asynchronous pins, pclk << clk_i/4
`timescale 1ns/1ps
`include "bvc_regs.svh"

module bvc_capture (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// video pins
	input  wire logic        pclk_i,
	input  wire logic [9:0]  video_data_in_i,
	// derived timing
	output logic             hsync_o,
	output logic             vsync_o,
	output logic             field_o,
	output logic             hactive_o,
	// packed pixel words
	output logic      [31:0] word_o,
	output logic             word_valid_o
);

	// registers
	logic [31:0] cfg_ff, nxt_cfg, hwin_ff, nxt_hwin;
	logic [31:0] llen_ff, nxt_llen, vsize_ff, nxt_vsize;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        ack_ff, nxt_ack;
	logic        pclk_d_ff;
	bvc_pkg::bvc_trc_e state_ff, nxt_state;
	logic        hactive_ff, nxt_hactive, field_ff, nxt_field;
	logic        vblank_ff, nxt_vblank, hsync_ff, nxt_hsync;
	logic        vsync_ff, nxt_vsync;
	logic [15:0] pix_cnt_ff, nxt_pix_cnt, line_cnt_ff, nxt_line_cnt;
	logic [1:0]  idx_ff, nxt_idx;
	logic [31:0] acc_ff, nxt_acc, word_ff, nxt_word;
	logic        wvalid_ff, nxt_wvalid;

	// combinational
	logic [10:0] pin_s;
	logic        mode_en, w10, inv, ecc, edge_sel;
	logic        rise, fall, sample_stb;
	logic [9:0]  raw, view;
	logic        is_ones, is_zero, code_stb, pix_stb, in_win, take;
	logic        f_dec, v_dec, h_dec, fixed;
	logic        req, wr;

	assign mode_en  = cfg_ff[`BVC_CFG_EN];
	assign w10      = cfg_ff[`BVC_CFG_W10];
	assign inv      = cfg_ff[`BVC_CFG_INV];
	assign ecc      = cfg_ff[`BVC_CFG_ECC];
	assign edge_sel = cfg_ff[`BVC_CFG_EDGE];

	// only clock and data pins cross in
	bvc_sync #(.W(11)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({pclk_i, video_data_in_i}),
		.sync_o  (pin_s)
	);

	// edge of the synchronised pixel clock
	always_comb begin
		rise       = pin_s[10] & ~pclk_d_ff;
		fall       = ~pin_s[10] & pclk_d_ff;
		sample_stb = edge_sel ? fall : rise;
	end

	// invert before anything looks at the data
	assign raw = pin_s[9:0] ^ {10{inv}};

	// 8-bit sample sits in the upper eight of the 10-bit view
	always_comb begin
		view    = w10 ? raw : {raw[7:0], 2'b00};
		is_ones = (view == (w10 ? `BVC_ONES10 : `BVC_ONES8));
		is_zero = (view == 10'h000);
	end

	// status word needs its fixed one bit
	assign code_stb = sample_stb && (state_ff == bvc_pkg::TRC_Z2) &&
		view[`BVC_XY_ONE];

	bvc_fvh_fix u_fix (
		.xy_i     (view),
		.ecc_en_i (ecc),
		.f_o      (f_dec),
		.v_o      (v_dec),
		.h_o      (h_dec),
		.fixed_o  (fixed)
	);

	// preamble tracker; any break restarts the search
	always_comb begin
		nxt_state = state_ff;
		if (!mode_en) begin
			nxt_state = bvc_pkg::TRC_SEEK;
		end else if (sample_stb) begin
			unique case (state_ff)
				bvc_pkg::TRC_SEEK: begin
					if (is_ones) nxt_state = bvc_pkg::TRC_FF;
				end
				bvc_pkg::TRC_FF: begin
					if (is_zero) nxt_state = bvc_pkg::TRC_Z1;
					else if (!is_ones) nxt_state = bvc_pkg::TRC_SEEK;
				end
				bvc_pkg::TRC_Z1: begin
					nxt_state = is_zero ? bvc_pkg::TRC_Z2 : bvc_pkg::TRC_SEEK;
				end
				bvc_pkg::TRC_Z2: begin
					nxt_state = bvc_pkg::TRC_SEEK;
				end
			endcase
		end
	end

	// timing only from decoded codes; flag meaning
	always_comb begin
		nxt_hactive  = hactive_ff;
		nxt_field    = field_ff;
		nxt_vblank   = vblank_ff;
		nxt_hsync    = 1'b0;
		nxt_vsync    = 1'b0;
		nxt_line_cnt = line_cnt_ff;
		if (!mode_en) begin
			nxt_hactive = 1'b0;
		end else if (code_stb) begin
			nxt_field   = f_dec;
			nxt_vblank  = v_dec;
			nxt_hactive = ~h_dec;
			nxt_hsync   = h_dec;
			nxt_vsync   = v_dec & ~vblank_ff;
			if (v_dec) begin
				nxt_line_cnt = 16'h0000;
			end else if (h_dec && hactive_ff) begin
				nxt_line_cnt = line_cnt_ff + 16'h0001;
			end
		end
	end

	// valid samples never take the all-ones value, so one ends the line
	assign pix_stb = mode_en && sample_stb && hactive_ff && !is_ones &&
		(state_ff == bvc_pkg::TRC_SEEK);

	// capture window from the programmed limits
	always_comb begin
		in_win = (pix_cnt_ff >= hwin_ff[15:0]) &&
			(pix_cnt_ff <= hwin_ff[31:16]) &&
			(pix_cnt_ff < llen_ff[15:0]) &&
			(line_cnt_ff < vsize_ff[15:0]) && !vblank_ff;
		take = pix_stb && in_win;
	end

	// pixel packing; a partial word is dropped at the next SAV
	always_comb begin
		nxt_pix_cnt = pix_cnt_ff;
		nxt_idx     = idx_ff;
		nxt_acc     = acc_ff;
		nxt_word    = word_ff;
		nxt_wvalid  = 1'b0;
		if (code_stb && !h_dec) begin
			nxt_pix_cnt = 16'h0000;
			nxt_idx     = 2'b00;
		end else if (pix_stb) begin
			nxt_pix_cnt = pix_cnt_ff + 16'h0001;
		end
		if (take) begin
			if (w10) begin
				nxt_acc[idx_ff[0]*16 +: 16] = {6'h00, raw};
				nxt_idx = {1'b0, ~idx_ff[0]};
				if (idx_ff[0]) begin
					nxt_word   = {6'h00, raw, acc_ff[15:0]};
					nxt_wvalid = 1'b1;
				end
			end else begin
				nxt_acc[idx_ff*8 +: 8] = raw[7:0];
				nxt_idx = idx_ff + 2'b01;
				if (idx_ff == 2'b11) begin
					nxt_word   = {raw[7:0], acc_ff[23:0]};
					nxt_wvalid = 1'b1;
				end
			end
		end
	end

	// byte-lane merge for writes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) old[b*8 +: 8] = dat[b*8 +: 8];
		end
		merge = old;
	endfunction

	// config and window registers read and written here
	// ack one cycle after the request; writes land on the ack edge
	always_comb begin
		req       = wb_cyc_i && wb_stb_i;
		wr        = req && wb_we_i && ack_ff;
		nxt_ack   = req && !ack_ff;
		nxt_rdata = rdata_ff;
		nxt_cfg   = cfg_ff;
		nxt_hwin  = hwin_ff;
		nxt_llen  = llen_ff;
		nxt_vsize = vsize_ff;
		if (req && !ack_ff) begin
			unique case (wb_adr_i)
				`BVC_OFF_CFG:   nxt_rdata = {27'h0, cfg_ff[4:0]};
				`BVC_OFF_HWIN:  nxt_rdata = hwin_ff;
				`BVC_OFF_LLEN:  nxt_rdata = llen_ff;
				`BVC_OFF_VSIZE: nxt_rdata = vsize_ff;
				`BVC_OFF_STAT:  nxt_rdata = {line_cnt_ff, 13'h0,
					hactive_ff, vblank_ff, field_ff};
				default:        nxt_rdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			unique case (wb_adr_i)
				`BVC_OFF_CFG:   nxt_cfg = merge(cfg_ff, wb_dat_i & 32'h1F,
					wb_sel_i);
				`BVC_OFF_HWIN:  nxt_hwin = merge(hwin_ff, wb_dat_i, wb_sel_i);
				// upper half stays zero: data masked, old upper already zero
				`BVC_OFF_LLEN:  nxt_llen = merge(llen_ff,
					wb_dat_i & 32'h0000_FFFF, wb_sel_i);
				`BVC_OFF_VSIZE: nxt_vsize = merge(vsize_ff,
					wb_dat_i & 32'h0000_FFFF, wb_sel_i);
				default: ;
			endcase
		end
	end

	// all state registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff      <= `BVC_CFG_RST;
			hwin_ff     <= `BVC_HWIN_RST;
			llen_ff     <= `BVC_LLEN_RST;
			vsize_ff    <= `BVC_VSIZE_RST;
			rdata_ff    <= 32'h0000_0000;
			ack_ff      <= 1'b0;
			pclk_d_ff   <= 1'b0;
			state_ff    <= bvc_pkg::TRC_SEEK;
			hactive_ff  <= 1'b0;
			field_ff    <= 1'b0;
			vblank_ff   <= 1'b0;
			hsync_ff    <= 1'b0;
			vsync_ff    <= 1'b0;
			line_cnt_ff <= 16'h0000;
			pix_cnt_ff  <= 16'h0000;
			idx_ff      <= 2'b00;
			acc_ff      <= 32'h0000_0000;
			word_ff     <= 32'h0000_0000;
			wvalid_ff   <= 1'b0;
		end else begin
			cfg_ff      <= nxt_cfg;
			hwin_ff     <= nxt_hwin;
			llen_ff     <= nxt_llen;
			vsize_ff    <= nxt_vsize;
			rdata_ff    <= nxt_rdata;
			ack_ff      <= nxt_ack;
			pclk_d_ff   <= pin_s[10];
			state_ff    <= nxt_state;
			hactive_ff  <= nxt_hactive;
			field_ff    <= nxt_field;
			vblank_ff   <= nxt_vblank;
			hsync_ff    <= nxt_hsync;
			vsync_ff    <= nxt_vsync;
			line_cnt_ff <= nxt_line_cnt;
			pix_cnt_ff  <= nxt_pix_cnt;
			idx_ff      <= nxt_idx;
			acc_ff      <= nxt_acc;
			word_ff     <= nxt_word;
			wvalid_ff   <= nxt_wvalid;
		end
	end

	// outputs
	assign wb_dat_o     = rdata_ff;
	assign wb_ack_o     = ack_ff;
	assign hsync_o      = hsync_ff;
	assign vsync_o      = vsync_ff;
	assign field_o      = field_ff;
	assign hactive_o    = hactive_ff;
	assign word_o       = word_ff;
	assign word_valid_o = wvalid_ff;

	// checks
	property p_edge;
		@(posedge clk_i) disable iff (rst_i)
		sample_stb |-> pin_s[10] == !edge_sel && $past(pin_s[10]) == edge_sel;
	endproperty
	a_edge: assert property (p_edge) else $error("wrong pclk edge");

	property p_pre;
		@(posedge clk_i) disable iff (rst_i)
		mode_en && sample_stb && state_ff == bvc_pkg::TRC_SEEK && is_ones
		|=> state_ff == bvc_pkg::TRC_FF;
	endproperty
	a_pre: assert property (p_pre) else $error("preamble missed");

	property p_off;
		@(posedge clk_i) disable iff (rst_i)
		!mode_en ##1 !mode_en |-> !hactive_ff && !word_valid_o;
	endproperty
	a_off: assert property (p_off) else $error("active while off");

	property p_eav;
		@(posedge clk_i) disable iff (rst_i)
		mode_en && code_stb && h_dec |=> hsync_o && !hactive_o ##1 !hsync_o;
	endproperty
	a_eav: assert property (p_eav) else $error("eav not handled");

	property p_sav;
		@(posedge clk_i) disable iff (rst_i)
		mode_en && code_stb && !h_dec |=> hactive_o && pix_cnt_ff == 16'h0;
	endproperty
	a_sav: assert property (p_sav) else $error("sav not handled");

	property p_fld;
		@(posedge clk_i) disable iff (rst_i)
		mode_en && code_stb |=> field_o == $past(f_dec) &&
			vblank_ff == $past(v_dec);
	endproperty
	a_fld: assert property (p_fld) else $error("field flag wrong");

	property p_pack8;
		@(posedge clk_i) disable iff (rst_i)
		take && !w10 && idx_ff == 2'b11 |=> word_valid_o &&
			word_o[31:24] == $past(raw[7:0]);
	endproperty
	a_pack8: assert property (p_pack8) else $error("bad packing");

	property p_raw;
		@(posedge clk_i) disable iff (rst_i)
		code_stb && !ecc |-> {f_dec, v_dec, h_dec} == view[8:6];
	endproperty
	a_raw: assert property (p_raw) else $error("flags altered");

	property p_fix;
		@(posedge clk_i) disable iff (rst_i)
		code_stb && ecc && view[9:5] == 5'b11011 && view[4:2] == 3'b101
		|-> {f_dec, v_dec, h_dec} == 3'b001;
	endproperty
	a_fix: assert property (p_fix) else $error("no correction");

	property p_ack;
		@(posedge clk_i) disable iff (rst_i)
		req && !ack_ff |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus ack timing");

	c_sav: cover property (@(posedge clk_i) code_stb && !h_dec);
	c_eav: cover property (@(posedge clk_i) code_stb && h_dec);
	c_w10: cover property (@(posedge clk_i) word_valid_o && w10);
	c_fix: cover property (@(posedge clk_i) code_stb && fixed);

endmodule

// ==== rtl/bvc_regs.svh ====
// register offsets, field positions and reset values of the capture port
// assumes byte addressing on a 32-bit classic wishbone bus
`ifndef BVC_REGS_SVH
`define BVC_REGS_SVH

// register byte offsets
`define BVC_OFF_CFG   8'h00
`define BVC_OFF_HWIN  8'h04
`define BVC_OFF_LLEN  8'h08
`define BVC_OFF_VSIZE 8'h0C
`define BVC_OFF_STAT  8'h10

// config register bit positions
`define BVC_CFG_EN   0
`define BVC_CFG_W10  1
`define BVC_CFG_INV  2
`define BVC_CFG_ECC  3
`define BVC_CFG_EDGE 4

// reset values
`define BVC_CFG_RST   32'h0000_0000
`define BVC_HWIN_RST  32'hFFFF_0000
`define BVC_LLEN_RST  32'h0000_FFFF
`define BVC_VSIZE_RST 32'h0000_FFFF

// timing reference codes in the 10-bit view
`define BVC_ONES10 10'h3FF
`define BVC_ONES8  10'h3FC
`define BVC_XY_ONE 9
`define BVC_XY_F   8
`define BVC_XY_V   7
`define BVC_XY_H   6

`endif

// ==== rtl/bvc_pkg.sv ====
// types shared by the embedded-sync capture port
// assumes nothing beyond a systemverilog compiler
package bvc_pkg;

	// preamble tracker, one-hot
	typedef enum logic [3:0] {
		TRC_SEEK = 4'b0001,
		TRC_FF   = 4'b0010,
		TRC_Z1   = 4'b0100,
		TRC_Z2   = 4'b1000
	} bvc_trc_e;

endpackage

// ==== rtl/bvc_sync.sv ====
// two-stage synchroniser for a bus of pin levels
// assumes each bit is a level that holds for several clk_i periods
`timescale 1ns/1ps

module bvc_sync #(
	parameter int W = 11
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_i;
			sync_ff <= meta_ff;
		end
	end

	assign sync_o = sync_ff;

endmodule

// ==== rtl/bvc_fvh_fix.sv ====
// corrects the F, V, H flags of a status word using its protection bits
// assumes the status word in the 10-bit view; purely combinational
`timescale 1ns/1ps

module bvc_fvh_fix (
	// status word and control
	input  wire logic [9:0] xy_i,
	input  wire logic       ecc_en_i,
	// decoded flags
	output logic            f_o,
	output logic            v_o,
	output logic            h_o,
	output logic            fixed_o
);

	// protection bits for a flag triple {f,v,h}
	function automatic logic [3:0] prot(input logic [2:0] fvh);
		prot = {fvh[1] ^ fvh[0], fvh[2] ^ fvh[0], fvh[2] ^ fvh[1],
			fvh[2] ^ fvh[1] ^ fvh[0]};
	endfunction

	logic [6:0] rx;
	logic [7:0] hit;
	logic [2:0] pick;
	logic       found;

	assign rx = xy_i[8:2];

	for (genvar g = 0; g < 8; g++) begin : g_cand
		logic [6:0] diff;
		assign diff = {3'(g), prot(3'(g))} ^ rx;
		assign hit[g] = ($countones(diff) <= 1);
	end

	// nearest codeword; minimum distance four keeps it unique
	always_comb begin
		pick  = rx[6:4];
		found = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (hit[i]) begin
				pick  = 3'(i);
				found = 1'b1;
			end
		end
	end

	always_comb begin
		if (ecc_en_i && found) begin
			{f_o, v_o, h_o} = pick;
			fixed_o = (rx != {pick, prot(pick)});
		end else begin
			{f_o, v_o, h_o} = rx[6:4];
			fixed_o = 1'b0;
		end
	end

endmodule

// ==== tb/bvc_src_model.sv ====
// behavioural video source: sends embedded-sync lines on data and pclk
// assumes the bench sets width and inversion before each line
`timescale 1ns/1ps

module bvc_src_model (
	// link settings from the bench
	input  wire logic       w10_i,
	input  wire logic       inv_i,
	// video pins
	output logic            pclk_o,
	output logic [9:0]      data_o
);
	logic [1:0] tog;

	// pclk stands still low outside lines
	initial begin
		pclk_o = 1'b0;
		data_o = 10'h000;
		tog = 2'b00;
	end

	function automatic logic [9:0] xy(input logic f, v, h);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
	endfunction

	// one sample in the 10-bit view; unused lines keep moving
	task automatic put(input logic [9:0] w);
		logic [9:0] d;
		d = w10_i ? w : {tog, w[9:2]};
		data_o = inv_i ? ~d : d;
		tog = tog + 2'b01;
		// data settles 31 ns before the rising edge and 94 ns before the falling edge
		#31.25 pclk_o = 1'b1;
		#62.5 pclk_o = 1'b0;
		#31.25;
	endtask

	task automatic line(input logic f, v, input int n,
		input logic [9:0] b, er);
		logic [9:0] p;
		put(10'h3FF); put(10'h000); put(10'h000); put(xy(f, v, 1'b0) ^ er);
		for (int i = 0; i < n; i++) begin
			p = b + 10'(i);
			put(w10_i ? p : {p[7:0], 2'b00});
		end
		put(10'h3FF); put(10'h000); put(10'h000); put(xy(f, v, 1'b1) ^ er);
		// released: never leave the last value standing
		data_o = ~data_o;
	endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the embedded-sync capture port
// assumes the source model drives the video pins, bench drives wishbone
`timescale 1ns/1ps
`include "bvc_regs.svh"

module testbench;
	logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, word_o, rd;
	logic        wb_ack_o, pclk_i, hsync_o, vsync_o, field_o, hactive_o;
	logic        word_valid_o, w10, inv;
	logic [9:0]  video_data_in_i;
	logic [31:0] wq[$];
	int          failures, compares, n_hs, n_vs, n_act;

	bvc_capture dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pclk_i(pclk_i),
		.video_data_in_i(video_data_in_i), .hsync_o(hsync_o),
		.vsync_o(vsync_o), .field_o(field_o), .hactive_o(hactive_o),
		.word_o(word_o), .word_valid_o(word_valid_o));
	bvc_src_model src (.w10_i(w10), .inv_i(inv), .pclk_o(pclk_i),
		.data_o(video_data_in_i));

	// 200 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// collect words and count timing pulses
	always @(posedge clk_i) begin
		if (word_valid_o === 1'b1) wq.push_back(word_o);
		if (hsync_o === 1'b1) n_hs++;
		if (vsync_o === 1'b1) n_vs++;
		if (hactive_o === 1'b1) n_act++;
	end

	task automatic print_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	// classic single cycle; waits for ack under a bound
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
		wb_adr_i <= a; wb_dat_i <= wd; wb_sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		d = wb_dat_o;
		if (n >= 20) chk("ack", 32'h1, 32'h0);
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// program config, send one line, let the sync stages drain
	task automatic run(input logic [4:0] cfg, input logic f, v,
		input int n, input logic [9:0] b, er);
		xfer(1'b1, `BVC_OFF_CFG, {27'h0, cfg}, rd);
		w10 = cfg[1];
		inv = cfg[2];
		wq.delete(); n_hs = 0; n_vs = 0; n_act = 0;
		src.line(f, v, n, b, er);
		repeat (30) @(posedge clk_i);
	endtask

	task automatic words(input int n, input logic [31:0] a, c);
		chk("word count", 32'(n), 32'(wq.size()));
		if (wq.size() > 0 && n > 0) chk("word 0", a, wq[0]);
		if (wq.size() > 1 && n > 1) chk("word 1", c, wq[1]);
	endtask

	// bounded run in case the port hangs
	initial begin
		#200000;
		failures++;
		print_verdict();
	end

	// main sequence
	initial begin
		logic [7:0]  ra [5];
		logic [31:0] rv [5];
		ra = '{`BVC_OFF_CFG, `BVC_OFF_HWIN, `BVC_OFF_LLEN, `BVC_OFF_VSIZE,
			8'h14};
		rv = '{`BVC_CFG_RST, `BVC_HWIN_RST, `BVC_LLEN_RST, `BVC_VSIZE_RST,
			32'h0};
		rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
		wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
		w10 = 1'b0; inv = 1'b0; failures = 0; compares = 0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, unmapped place reads zero
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, ra[i], 32'h0, rd);
			chk("reg reset", rv[i], rd);
		end
		xfer(1'b1, `BVC_OFF_CFG, 32'hFFFF_FFFF, rd);
		xfer(1'b0, `BVC_OFF_CFG, 32'h0, rd);
		chk("cfg bits", 32'h0000_001F, rd);
		// 8-bit, rising edge
		run(5'h01, 1'b0, 1'b0, 8, 10'h010, 10'h000);
		words(2, 32'h1312_1110, 32'h1716_1514);
		chk("hsync", 32'd1, 32'(n_hs));
		chk("hactive seen", 32'h1, {31'h0, n_act > 0});
		chk("hactive end", 32'h0, {31'h0, hactive_o});
		// 10-bit width
		run(5'h03, 1'b0, 1'b0, 4, 10'h200, 10'h000);
		words(2, 32'h0201_0200, 32'h0203_0202);
		// inverted data, falling edge, field 2
		run(5'h15, 1'b1, 1'b0, 4, 10'h020, 10'h000);
		words(1, 32'h2322_2120, 32'h0);
		chk("field", 32'h1, {31'h0, field_o});
		// three active lines counted, field 2, idle between lines
		xfer(1'b0, `BVC_OFF_STAT, 32'h0, rd);
		chk("stat field", 32'h0003_0001, rd);
		// vertical blanking line: no words, one vsync
		run(5'h01, 1'b1, 1'b1, 4, 10'h030, 10'h000);
		words(0, 32'h0, 32'h0);
		chk("vsync", 32'd1, 32'(n_vs));
		// F flipped in both codes, corrected then raw
		run(5'h09, 1'b0, 1'b0, 4, 10'h040, 10'h100);
		words(1, 32'h4342_4140, 32'h0);
		chk("field fixed", 32'h0, {31'h0, field_o});
		run(5'h01, 1'b0, 1'b0, 4, 10'h040, 10'h100);
		chk("field raw", 32'h1, {31'h0, field_o});
		// window of pixels 2 to 5
		xfer(1'b1, `BVC_OFF_HWIN, 32'h0005_0002, rd);
		run(5'h01, 1'b0, 1'b0, 8, 10'h050, 10'h000);
		words(1, 32'h5554_5352, 32'h0);
		xfer(1'b1, `BVC_OFF_HWIN, `BVC_HWIN_RST, rd);
		// disabled port ignores the line
		run(5'h00, 1'b0, 1'b0, 4, 10'h060, 10'h000);
		words(0, 32'h0, 32'h0);
		chk("idle hactive", 32'h0, 32'(n_act));
		chk("idle hsync", 32'h0, 32'(n_hs));
		print_verdict();
	end
endmodule
